// ===== irsd_pkg.sv
// Package: constants for the chopper gate sequencer
// Assumes: a single clock domain at 200 MHz driven from the wheel PLL
package irsd_pkg;
  // Fast clock ticks per segment (PLL multiplier)
  localparam int TICKS_PER_SEG = 10;
  // Gate window inside a segment half, in fast ticks from the segment edge
  localparam int GATE_START = 1;
  localparam int GATE_STOP = 4;
  // Clock rate and activity timeout
  localparam int CLK_HZ = 200000000;
  localparam int ACT_TIMEOUT_MS = 100;
  localparam int ACT_TIMEOUT_CYC = CLK_HZ / 1000 * ACT_TIMEOUT_MS;
  // Reset values
  localparam logic [3:0] GATES_RST = 4'h0;
  // Sequencer states
  typedef enum logic [2:0] {
    IRSD_IDLE = 3'b001,
    IRSD_WAIT = 3'b010,
    IRSD_RUN = 3'b100
  } irsd_state_t;
endpackage

// ===== irsd_sync_edge.sv
// Module: two-flop synchroniser with edge detector and activity watch
// Assumes: asynchronous sensor level in, clk_sys domain out
`timescale 1ns/100ps
`default_nettype none
module irsd_sync_edge #(
  parameter int TIMEOUT = irsd_pkg::ACT_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Sensor
  input wire logic sense_in,
  // Conditioned outputs
  output logic level,
  output logic rise,
  output logic fall,
  output logic active
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic [31:0] idle_cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= sense_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      idle_cnt_reg <= 32'(TIMEOUT);
    end else if (sync_reg != last_reg) begin
      idle_cnt_reg <= 32'h0;
    end else if (idle_cnt_reg < 32'(TIMEOUT)) begin
      idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end
  end

  assign level = last_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
  assign active = idle_cnt_reg < 32'(TIMEOUT);
endmodule
`default_nettype wire

// ===== irsd_gate_seq.sv
// Module: sample-and-hold gate sequencer for the synchronous demodulator
// Assumes: clk_sys from the PLL; sensors are Schmitt-conditioned levels
`timescale 1ns/100ps
`default_nettype none
// Function
// - Four gate strobes exist, two for the measure half, two for reference.
// - The light gate runs while segment is high, the dark gate while low.
// - Gates are decoded only from the conditioned segment and phase levels.
// - Timing uses the fast clock locked at ten ticks per segment.
// - Each gate is limited to the centre ticks of its segment half.
// - Two LEDs follow phase and segment sensor activity; stuck means fault.
// - A dark calibration request opens the dark switch.
// - Electrical test without a dark calibration request routes the simulated waveform via the dark switch.
// - Results are two held values picked up at measure and reference gates.
module irsd_gate_seq #(
  parameter int TIMEOUT = irsd_pkg::ACT_TIMEOUT_CYC,
  parameter int SEG_TICKS = irsd_pkg::TICKS_PER_SEG
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Sensors and PLL
  input wire logic segment_sense,
  input wire logic phase_sense,
  input wire logic pll_tick,
  input wire logic pll_locked,
  // Host commands
  input wire logic dark_cal_req,
  input wire logic elec_test_req,
  // Gate strobes
  output logic measure_gate,
  output logic measure_dark_gate,
  output logic reference_gate,
  output logic reference_dark_gate,
  // Switches
  output logic dark_switch_open,
  output logic test_wave_en,
  // Held-value capture strobes
  output logic measure_level,
  output logic reference_level,
  // LEDs
  output logic phase_activity_led,
  output logic segment_activity_led
);
  // ---------------------------------------------------------------
  // Sensor conditioning
  // ---------------------------------------------------------------
  logic seg_lvl, seg_rise, seg_fall, seg_act;
  logic ph_lvl, ph_act;

  irsd_sync_edge #(.TIMEOUT(TIMEOUT)) u_seg (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sense_in(segment_sense),
    .level(seg_lvl),
    .rise(seg_rise),
    .fall(seg_fall),
    .active(seg_act)
  );

  irsd_sync_edge #(.TIMEOUT(TIMEOUT)) u_ph (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sense_in(phase_sense),
    .level(ph_lvl),
    .rise(),
    .fall(),
    .active(ph_act)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  irsd_pkg::irsd_state_t state_reg, state_next;
  logic [7:0] tick_cnt_reg;
  logic [3:0] gates_reg;
  logic ok;

  assign ok = pll_locked & seg_act & ph_act;

  // Segment edge in either direction
  function automatic logic any_edge(input logic r, input logic f);
    any_edge = r | f;
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      irsd_pkg::IRSD_IDLE: begin
        if (ok) begin
          state_next = irsd_pkg::IRSD_WAIT;
        end
      end
      irsd_pkg::IRSD_WAIT: begin
        if (!ok) begin
          state_next = irsd_pkg::IRSD_IDLE;
        end else if (any_edge(seg_rise, seg_fall)) begin
          state_next = irsd_pkg::IRSD_RUN;
        end
      end
      irsd_pkg::IRSD_RUN: begin
        if (!ok) begin
          state_next = irsd_pkg::IRSD_IDLE;
        end
      end
      default: state_next = irsd_pkg::IRSD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= irsd_pkg::IRSD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_cnt_reg <= 8'h00;
    end else if (any_edge(seg_rise, seg_fall)) begin
      tick_cnt_reg <= 8'h00;
    end else if (pll_tick && tick_cnt_reg != 8'hFF) begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end

  function automatic logic in_window(input logic [7:0] t);
    in_window = t >= 8'(irsd_pkg::GATE_START)
      && t < 8'(irsd_pkg::GATE_STOP) && t < 8'(SEG_TICKS / 2);
  endfunction

  function automatic logic [3:0] gate_decode(input logic ph, input logic seg);
    case ({ph, seg})
      2'h3: gate_decode = 4'h1;
      2'h2: gate_decode = 4'h2;
      2'h1: gate_decode = 4'h4;
      2'h0: gate_decode = 4'h8;
      default: gate_decode = 4'h0;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gates_reg <= irsd_pkg::GATES_RST;
    end else if (state_reg != irsd_pkg::IRSD_RUN || !ok) begin
      gates_reg <= irsd_pkg::GATES_RST;
    end else if (!in_window(tick_cnt_reg)) begin
      gates_reg <= irsd_pkg::GATES_RST;
    end else begin
      gates_reg <= gate_decode(ph_lvl, seg_lvl);
    end
  end

  assign measure_gate = gates_reg[0];
  assign measure_dark_gate = gates_reg[1];
  assign reference_gate = gates_reg[2];
  assign reference_dark_gate = gates_reg[3];

  // ---------------------------------------------------------------
  // Held value capture, switches, LEDs
  // ---------------------------------------------------------------
  // measure held strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      measure_level <= 1'b0;
    end else begin
      measure_level <= gates_reg[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reference_level <= 1'b0;
    end else begin
      reference_level <= gates_reg[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dark_switch_open <= 1'b0;
    end else begin
      dark_switch_open <= dark_cal_req | elec_test_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      test_wave_en <= 1'b0;
    end else begin
      test_wave_en <= elec_test_req & ~dark_cal_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      phase_activity_led <= 1'b0;
    end else begin
      phase_activity_led <= ph_lvl;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      segment_activity_led <= 1'b0;
    end else begin
      segment_activity_led <= seg_lvl;
    end
  end
endmodule
`default_nettype wire

// ===== irsd_gate_seq_props.sv
// Checker: port properties of the gate sequencer
// Assumes: bound to irsd_gate_seq, one clock domain
`timescale 1ns/100ps
`default_nettype none
module irsd_gate_seq_chk #(
  parameter int TIMEOUT = irsd_pkg::ACT_TIMEOUT_CYC,
  parameter int SEG_TICKS = irsd_pkg::TICKS_PER_SEG
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Inputs
  input wire logic segment_sense,
  input wire logic phase_sense,
  input wire logic pll_tick,
  input wire logic pll_locked,
  input wire logic dark_cal_req,
  input wire logic elec_test_req,
  // Outputs
  input wire logic measure_gate,
  input wire logic measure_dark_gate,
  input wire logic reference_gate,
  input wire logic reference_dark_gate,
  input wire logic dark_switch_open,
  input wire logic test_wave_en,
  input wire logic measure_level,
  input wire logic reference_level,
  input wire logic phase_activity_led,
  input wire logic segment_activity_led
);
  logic [3:0] g;
  logic any_g;
  assign g = {measure_gate, measure_dark_gate, reference_gate,
    reference_dark_gate};
  assign any_g = |g;
  // Cycles since the segment sensor last moved
  logic [31:0] still_cnt;
  logic seg_last;
  always_ff @(posedge clk_sys) begin
    seg_last <= segment_sense;
    if (!reset_n || segment_sense != seg_last) begin
      still_cnt <= 32'h0;
    end else if (still_cnt != 32'hFFFFFFFF) begin
      still_cnt <= still_cnt + 32'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_one_gate: assert property ($onehot0(g))
    else $error("two gates at once");
  chk_meas_light: assert property ($rose(measure_gate) |->
    phase_sense && segment_sense) else $error("measure gate");
  chk_meas_dark: assert property ($rose(measure_dark_gate) |->
    phase_sense && !segment_sense) else $error("measure dark gate");
  chk_ref_light: assert property ($rose(reference_gate) |->
    !phase_sense && segment_sense) else $error("reference gate");
  chk_ref_dark: assert property ($rose(reference_dark_gate) |->
    !phase_sense && !segment_sense) else $error("reference dark gate");
  chk_gate_centre: assert property (@(posedge clk_sys)
    disable iff (!reset_n || !pll_locked)
    $rose(any_g) |-> any_g [*8] ##[1:6] !any_g) else $error("gate width");
  chk_lock_off: assert property (!pll_locked [*3] |-> g == 4'h0)
    else $error("gate while unlocked");
  chk_dark_sw: assert property (dark_cal_req |=>
    dark_switch_open && !test_wave_en) else $error("dark switch");
  chk_test_sw: assert property (elec_test_req && !dark_cal_req |=>
    test_wave_en && dark_switch_open) else $error("test switch");
  chk_held_strobe: assert property ({measure_level, reference_level} ==
    $past({measure_gate, reference_gate})) else $error("capture strobe");
  chk_led_seg: assert property ($stable(segment_sense) [*8] |->
    segment_activity_led == segment_sense) else $error("segment led");
  chk_led_phase: assert property ($stable(phase_sense) [*8] |->
    phase_activity_led == phase_sense) else $error("phase led");
  chk_idle_off: assert property (still_cnt > 32'(TIMEOUT + 8) |->
    g == 4'h0) else $error("gate while sensor idle");
  cover property ($rose(measure_gate));
  cover property ($rose(reference_dark_gate));
  cover property ($rose(test_wave_en));
  cover property (pll_tick && measure_gate);
endmodule
bind irsd_gate_seq irsd_gate_seq_chk #(.TIMEOUT(TIMEOUT),
  .SEG_TICKS(SEG_TICKS)) chk_i (.*);
`default_nettype wire

// ===== irsd_wheel_model.sv
// Model: chopper wheel sensors and PLL tick
// Assumes: one tick every 4 clk_sys cycles, sensors frozen when run is low
`timescale 1ns/100ps
`default_nettype none
module irsd_wheel_model (
  // Clock and control
  input wire logic clk_sys,
  input wire logic run,
  // Sensors and PLL
  output logic segment_sense,
  output logic phase_sense,
  output logic pll_tick
);
  logic [6:0] cnt = 7'h00;
  logic seg_reg = 1'b0;
  logic ph_reg = 1'b0;
  logic tick_reg = 1'b0;
  assign segment_sense = seg_reg;
  assign phase_sense = ph_reg;
  assign pll_tick = tick_reg;
  always @(posedge clk_sys) begin
    cnt <= (cnt == 7'h77) ? 7'h00 : cnt + 7'h01;
    tick_reg <= (cnt[1:0] == 2'h3);
    if (run) begin
      ph_reg <= (cnt < 7'h3C);
      seg_reg <= ((cnt % 7'h28) < 7'h14);
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Testbench: gate sequencer driven by the wheel model
// Assumes: package, design, checker and model compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin n_tests++; if ((v) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, v); end end
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic pll_locked = 1'b0;
  logic dark_cal_req = 1'b0;
  logic elec_test_req = 1'b0;
  logic run = 1'b0;
  logic segment_sense, phase_sense, pll_tick;
  logic measure_gate, measure_dark_gate, reference_gate, reference_dark_gate;
  logic dark_switch_open, test_wave_en, measure_level, reference_level;
  logic phase_activity_led, segment_activity_led;
  logic [3:0] g;
  logic [3:0] seen = 4'h0;
  logic [1:0] seen_lvl = 2'h0;
  logic [1:0] leds;
  localparam int TICK_CYC = 4;
  localparam int GATE_CYC =
    (irsd_pkg::GATE_STOP - irsd_pkg::GATE_START) * TICK_CYC;
  int width = 0;
  logic [1:0] v, r;
  logic [1:0] exp_q[$];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 41;
  assign g = {measure_gate, measure_dark_gate, reference_gate,
    reference_dark_gate};
  assign leds = {phase_activity_led, segment_activity_led};
  always #2.5 clk_sys = ~clk_sys;
  irsd_wheel_model irsd_wheel_model_i (.*);
  irsd_gate_seq #(.TIMEOUT(200)) irsd_gate_seq_i (.*);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    if (reset_n) seen <= seen | g;
    if (reset_n) seen_lvl <= seen_lvl | {measure_level, reference_level};
    if (|g) begin
      width++;
    end else if (width > 0) begin
      if (pll_locked) `CHK("gate width", GATE_CYC, width)
      width = 0;
    end
    if (exp_q.size() > 1) begin
      r = exp_q.pop_front();
      `CHK("switches", r, {dark_switch_open, test_wave_en})
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    pll_locked <= 1'b1;
    run <= 1'b1;
    @(posedge clk_sys);
    repeat (400) begin
      @(posedge clk_sys);
      v = 2'($random(seed));
      dark_cal_req <= v[0];
      elec_test_req <= v[1];
      exp_q.push_back({v[0] | v[1], v[1] & ~v[0]});
    end
    `CHK("gates seen", 4'hF, seen)
    `CHK("held strobes seen", 2'h3, seen_lvl)
    $display("test switches and gates done");
    pll_locked <= 1'b0;
    repeat (4) @(posedge clk_sys);
    repeat (40) begin
      @(negedge clk_sys);
      `CHK("gates unlocked", 4'h0, g)
    end
    @(posedge clk_sys);
    pll_locked <= 1'b1;
    run <= 1'b0;
    $display("test unlock done");
    repeat (260) @(negedge clk_sys);
    `CHK("gates idle", 4'h0, g)
    `CHK("leds", {phase_sense, segment_sense}, leds)
    $display("test idle done");
    complete_run();
  end
endmodule
`default_nettype wire
